// *** mad_noise_estimator.sv ***
// mad_noise_estimator: X/Y noise density estimator with Wishbone registers
// assumes samples arrive on the system clock with valid/ready handshake,
// one Wishbone classic slave, synchronous 50 MHz clock
// Function
// [RULE1] noise bandwidth from time constant and slope
// [RULE2] settle wait of 5T, 7T, 9T, 10T
// [RULE3] running moving-average mean per channel
// [RULE4] deviation is input minus current mean
// [RULE5] average absolute deviation, not RMS
// [RULE6] one fixed factor turns deviation into RMS
// [RULE7] both channels update at 512 Hz
// [RULE8] averaging time 10 to 80 time constants; the code offers only 16T, 32T and 64T
// [RULE9] result normalised to volts per root hertz
// [RULE10] estimator runs whether displayed or not
// [RULE11] display selector routes chosen noise estimate
// [RULE12] sensitivity change forces re-settling before valid
// [RULE13] averages are first-order exponential accumulators
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module mad_noise_estimator #(
    parameter int TICK_CYCLES = noise_pkg::TICK_CYCLES
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        samp_valid_i,
    output logic             samp_ready_o,
    input  wire logic [23:0] samp_x_i,
    input  wire logic [23:0] samp_y_i,
    output logic      [31:0] display_o,
    output logic             display_valid_o,
    output logic             noise_valid_o
);
    localparam int DW     = noise_pkg::DATA_W;
    localparam int AW     = noise_pkg::ACC_W;
    localparam int FR     = noise_pkg::ACC_FRAC;
    localparam int SW     = noise_pkg::SETTLE_W;
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int LVL_W  = $clog2(noise_pkg::FIFO_DEPTH + 1);
    typedef enum logic [1:0] {ST_SEED, ST_SETTLE, ST_VALID} est_state_t;
    // sign-extended value placed above the accumulator fraction
    function automatic logic signed [AW-1:0] to_acc(input logic signed [DW:0] v);
        to_acc = {{(AW-DW-1-FR){v[DW]}}, v, {FR{1'b0}}};
    endfunction

    // one step of an exponential average with weight 2^-sh
    function automatic logic signed [AW-1:0] ema_step(input logic signed [AW-1:0] acc,
                                                      input logic signed [AW-1:0] tgt,
                                                      input logic [4:0]           sh);
        logic signed [AW:0] diff;
        diff     = {tgt[AW-1], tgt} - {acc[AW-1], acc};
        ema_step = acc + AW'(diff >>> sh);
    endfunction

    // MAD-to-RMS factor folded with 1/sqrt(bandwidth)
    function automatic logic [14:0] scale_q16(input logic [1:0] slope, input logic odd);
        case (slope)
            noise_pkg::SLOPE_6DB:  scale_q16 = odd ? noise_pkg::SCALE_6DB_ODD
                                                   : noise_pkg::SCALE_6DB_EVEN;
            noise_pkg::SLOPE_12DB: scale_q16 = odd ? noise_pkg::SCALE_12DB_ODD
                                                   : noise_pkg::SCALE_12DB_EVEN;
            noise_pkg::SLOPE_18DB: scale_q16 = odd ? noise_pkg::SCALE_18DB_ODD
                                                   : noise_pkg::SCALE_18DB_EVEN;
            default:               scale_q16 = odd ? noise_pkg::SCALE_24DB_ODD
                                                   : noise_pkg::SCALE_24DB_EVEN;
        endcase
    endfunction

    // byte-lane merge of a Wishbone write
    function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
        for (int b = 0; b < 4; b++) begin
            old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
        wb_merge = old;
    endfunction

    // registers, state and combinational helpers
    logic [TICK_W-1:0]      tick_cnt_q;
    logic                   tick_q;
    logic [31:0]            ctrl_q;
    logic [31:0]            sens_q;
    logic                   restart_q;
    est_state_t             state_q;
    logic [SW-1:0]          settle_q;
    logic signed [AW-1:0]   mean_q [2];
    logic signed [AW-1:0]   mad_q  [2];
    logic [31:0]            noise_q [2];
    logic signed [DW-1:0]   last_q [2];
    logic                   upd_q;
    logic                   fifo_valid;
    logic [2*DW-1:0]        fifo_data;
    logic [LVL_W-1:0]       fifo_level;
    logic                   pop;
    logic [3:0]             tc_exp;
    logic [1:0]             slope;
    logic [4:0]             avg_ext;
    logic [4:0]             avg_sh;
    logic [3:0]             wait_mult;
    logic [SW-1:0]          settle_load;
    logic signed [DW-1:0]   chan_in [2];
    logic signed [DW-1:0]   mean_v  [2];
    logic [DW:0]            dev_abs [2];
    logic                   wb_req;
    logic                   wb_wr;
    logic [31:0]            rd_mux;
    logic [31:0]            ctrl_new;

    // sample buffer between filter chain and estimator
    noise_fifo #(
        .WIDTH (2*DW),
        .DEPTH (noise_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (ref_clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (samp_valid_i),
        .in_ready_o  (samp_ready_o),
        .in_data_i   ({samp_x_i, samp_y_i}),
        .out_valid_o (fifo_valid),
        .out_ready_i (tick_q),
        .out_data_o  (fifo_data),
        .level_o     (fifo_level)
    );

    // 512 Hz update tick
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1; // [RULE7]
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end
    // one pair consumed per tick; a late pair waits for the next
    assign pop = tick_q & fifo_valid; // [RULE7]

    // fields decoded from the control register
    always_comb begin
        tc_exp  = ctrl_q[noise_pkg::CTRL_TC_LSB +: 4];
        slope   = ctrl_q[noise_pkg::CTRL_SLOPE_LSB +: 2];
        avg_ext = noise_pkg::AVG_MIN_EXP + {3'b000, ctrl_q[noise_pkg::CTRL_AVG_LSB +: 2]};
        if (avg_ext > noise_pkg::AVG_MAX_EXP) begin
            avg_ext = noise_pkg::AVG_MAX_EXP; // keeps averaging within 16T..64T [RULE8]
        end
        avg_sh = {1'b0, tc_exp} + avg_ext; // [RULE8]
    end

    // filter wait time and settle period in ticks
    always_comb begin
        case (slope)
            noise_pkg::SLOPE_6DB:  wait_mult = noise_pkg::WAIT_6DB;  // [RULE2]
            noise_pkg::SLOPE_12DB: wait_mult = noise_pkg::WAIT_12DB; // [RULE2]
            noise_pkg::SLOPE_18DB: wait_mult = noise_pkg::WAIT_18DB; // [RULE2]
            default:               wait_mult = noise_pkg::WAIT_24DB; // [RULE2]
        endcase
        settle_load = (SW'(wait_mult) << tc_exp)
                    + (SW'(noise_pkg::SETTLE_AVG_MULT) << avg_sh);
    end

    // per-channel input, mean and absolute deviation
    always_comb begin
        chan_in[0] = fifo_data[DW +: DW];
        chan_in[1] = fifo_data[0 +: DW];
        for (int c = 0; c < 2; c++) begin
            logic signed [DW:0] dev;
            dev        = '0;
            mean_v[c]  = mean_q[c][FR +: DW];
            dev        = {chan_in[c][DW-1], chan_in[c]}
                       - {mean_v[c][DW-1], mean_v[c]}; // [RULE4]
            dev_abs[c] = dev[DW] ? (DW+1)'(-dev) : dev; // [RULE5]
        end
    end

    // running mean and mean absolute deviation of both channels
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < 2; c++) begin
                mean_q[c] <= '0;
                mad_q[c]  <= '0;
            end
        end else if (pop) begin
            for (int c = 0; c < 2; c++) begin
                if (state_q == ST_SEED) begin
                    mean_q[c] <= to_acc({chan_in[c][DW-1], chan_in[c]});
                    mad_q[c]  <= '0;
                end else begin
                    mean_q[c] <= ema_step(mean_q[c],
                                          to_acc({chan_in[c][DW-1], chan_in[c]}),
                                          avg_sh); // [RULE3] [RULE13]
                    mad_q[c]  <= ema_step(mad_q[c], to_acc(dev_abs[c]),
                                          avg_sh); // [RULE5] [RULE13]
                end
            end
        end
    end

    // latest raw sample for the plain X and Y display choices
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_q[0] <= '0;
            last_q[1] <= '0;
        end else if (pop) begin
            last_q[0] <= chan_in[0];
            last_q[1] <= chan_in[1];
        end
    end
    // noise density, the cycle after each update
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            upd_q      <= 1'b0;
            noise_q[0] <= '0;
            noise_q[1] <= '0;
        end else begin
            upd_q <= pop;
            if (upd_q) begin
                for (int c = 0; c < 2; c++) begin
                    noise_q[c] <= 32'((40'(mad_q[c][FR +: DW+1])
                                * 40'(scale_q16(slope, tc_exp[0])))
                                >> noise_pkg::SCALE_FRAC)
                                << tc_exp[3:1]; // [RULE1] [RULE6] [RULE9]
                end
            end
        end
    end

    // estimator state: seed, settle, valid
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q  <= ST_SEED;
            settle_q <= '0;
        end else if (restart_q) begin
            state_q  <= (state_q == ST_SEED) ? ST_SEED : ST_SETTLE; // [RULE12]
            settle_q <= settle_load; // [RULE2] [RULE12]
        end else if (pop) begin
            case (state_q)
                ST_SEED: begin
                    state_q  <= ST_SETTLE;
                    settle_q <= settle_load; // [RULE2]
                end
                ST_SETTLE: begin
                    if (settle_q <= SW'(1)) begin
                        state_q  <= ST_VALID;
                        settle_q <= '0;
                    end else begin
                        settle_q <= settle_q - 1'b1;
                    end
                end
                ST_VALID: state_q <= ST_VALID; // keeps running while shown or not [RULE10]
                default:  state_q <= ST_SEED;
            endcase
        end
    end

    // display quantity and validity
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            display_o       <= '0;
            display_valid_o <= 1'b0;
            noise_valid_o   <= 1'b0;
        end else begin
            display_valid_o <= upd_q;
            noise_valid_o   <= (state_q == ST_VALID) && !restart_q; // [RULE12]
            case (ctrl_q[noise_pkg::CTRL_SEL_LSB +: 2])
                noise_pkg::SEL_X:       display_o <= 32'(last_q[0]);
                noise_pkg::SEL_Y:       display_o <= 32'(last_q[1]);
                noise_pkg::SEL_X_NOISE: display_o <= noise_q[0]; // [RULE11]
                default:                display_o <= noise_q[1]; // [RULE11]
            endcase
        end
    end

    // Wishbone request decode
    assign wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wb_wr    = wb_req & wb_we_i;
    assign ctrl_new = wb_merge(ctrl_q, wb_dat_i, wb_sel_i) & noise_pkg::CTRL_MASK;
    // read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_mux = '0;
        case (wb_adr_i)
            noise_pkg::REG_CTRL:    rd_mux = ctrl_q;
            noise_pkg::REG_SENS:    rd_mux = sens_q;
            noise_pkg::REG_STATUS: begin
                rd_mux[noise_pkg::STAT_VALID_BIT]        = noise_valid_o;
                rd_mux[noise_pkg::STAT_SETTLE_BIT]       = (state_q != ST_VALID);
                rd_mux[noise_pkg::STAT_LEVEL_LSB +: LVL_W] = fifo_level;
            end
            noise_pkg::REG_X_NOISE: rd_mux = noise_q[0];
            noise_pkg::REG_Y_NOISE: rd_mux = noise_q[1];
            noise_pkg::REG_X_MEAN:  rd_mux = 32'(mean_v[0]);
            noise_pkg::REG_Y_MEAN:  rd_mux = 32'(mean_v[1]);
            noise_pkg::REG_X_MAD:   rd_mux = 32'(mad_q[0][FR +: DW+1]);
            noise_pkg::REG_Y_MAD:   rd_mux = 32'(mad_q[1][FR +: DW+1]);
            default:                rd_mux = '0;
        endcase
    end

    // ack and read data one cycle after the request
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : '0;
        end
    end

    // writable registers; filter or sensitivity changes restart settling
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q    <= noise_pkg::CTRL_RST;
            sens_q    <= noise_pkg::SENS_RST;
            restart_q <= 1'b0;
        end else begin
            restart_q <= 1'b0;
            if (wb_wr && wb_adr_i == noise_pkg::REG_CTRL) begin
                ctrl_q    <= ctrl_new;
                restart_q <= (ctrl_new[11:0] != ctrl_q[11:0]); // filter change [RULE2]
            end
            if (wb_wr && wb_adr_i == noise_pkg::REG_SENS) begin
                sens_q    <= wb_merge(sens_q, wb_dat_i, wb_sel_i) & noise_pkg::SENS_MASK;
                restart_q <= 1'b1; // [RULE12]
            end
        end
    end

endmodule

// *** mad_noise_estimator_assertions.sv ***
// mad_noise_estimator_checker: bus, stream and settling properties
// assumes binding to the estimator top; sees only its ports
`timescale 1ns/1ps
module mad_noise_estimator_checker (
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        samp_valid_i,
    input wire logic        samp_ready_o,
    input wire logic        display_valid_o,
    input wire logic        noise_valid_o
);
    logic taken_q;
    // a pair has entered since reset
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            taken_q <= 1'b0;
        else if (samp_valid_i && samp_ready_o)
            taken_q <= 1'b1;
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // request, sensitivity write, unmapped read
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence sens_wr_s;
        take_s ##0 (wb_we_i && wb_adr_i == noise_pkg::REG_SENS);
    endsequence
    sequence gap_rd_s;
        take_s ##0 (!wb_we_i && wb_adr_i == 8'h40);
    endsequence

    a_ack_next: assert property (take_s |=> wb_ack_o)
        else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data outside ack");
    a_gap_zero: assert property (gap_rd_s |=> wb_dat_o == 32'h0)
        else $error("unmapped not zero");
    a_sens_restart: assert property (sens_wr_s |-> ##2 (!noise_valid_o) [*8])
        else $error("valid kept");
    a_disp_gap: assert property (display_valid_o |=> (!display_valid_o) [*3])
        else $error("updates too close");
    a_disp_cause: assert property (display_valid_o |-> taken_q)
        else $error("update without pair");
    a_ready_fall: assert property ($fell(samp_ready_o) |-> $past(samp_valid_i))
        else $error("ready fell alone");
endmodule

bind mad_noise_estimator mad_noise_estimator_checker chk_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o),
    .display_valid_o(display_valid_o), .noise_valid_o(noise_valid_o)
);

// *** mad_noise_estimator_tb.sv ***
// mad_noise_estimator_tb: self-checking bench for the noise estimator
// assumes package, FIFO, design, source model and checker compiled first
`timescale 1ns/1ps
module mad_noise_estimator_tb;
    localparam int TICK  = 16;
    localparam int LIMIT = 30000;
    logic        ref_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b0, rnd = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] wdat = 32'h0, dat_o, disp_o, q;
    logic        ack, s_valid, s_ready, disp_valid, nvalid;
    logic [23:0] sx, sy, gx = 24'h0, cx, cy;
    logic [31:0] rq[$], dq[$];
    int          num_errors = 0, total_checks = 0, cycles = 0, n, f, t, r;
    int          waits[4] = '{5, 7, 9, 10};

    mad_noise_estimator #(.TICK_CYCLES(TICK)) mad_noise_estimator_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .samp_valid_i(s_valid), .samp_ready_o(s_ready), .samp_x_i(sx),
        .samp_y_i(sy), .display_o(disp_o), .display_valid_o(disp_valid),
        .noise_valid_o(nvalid));
    sample_source sample_source_inst (
        .clk_i(ref_clk_i), .rst_i(rst_i), .en_i(en), .x_i(gx), .y_i(cy),
        .ready_i(s_ready), .valid_o(s_valid), .x_o(sx), .y_o(sy));

    // 50 MHz clock
    initial forever #10 ref_clk_i = ~ref_clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // classic cycle; read data taken at ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hF;
        do @(posedge ref_clk_i); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // read, expected word queued
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    // monitor: oldest note against each answer
    always @(posedge ref_clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
            check(dat_o, rq.pop_front());
        if (disp_valid === 1'b1 && dq.size() > 0)
            check(disp_o, dq.pop_front());
    end

    // X source: random in the noisy phase
    always @(posedge ref_clk_i) gx <= rnd ? 24'($urandom_range(0, 32'h3FFF)) : cx;

    // hang guard
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(32'h1AAB122F));
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        // reset values, masking, unmapped place
        rd(noise_pkg::REG_CTRL, noise_pkg::CTRL_RST);
        rd(noise_pkg::REG_SENS, noise_pkg::SENS_RST);
        wb(1'b1, noise_pkg::REG_CTRL, 32'hFFFF_FFFF);
        rd(noise_pkg::REG_CTRL, noise_pkg::CTRL_MASK);
        wb(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        // constant pairs fill the FIFO
        cx = 24'($urandom);
        cy = 24'($urandom);
        @(posedge ref_clk_i);
        en <= 1'b1;
        while (s_ready !== 1'b0) @(posedge ref_clk_i);
        wb(1'b0, noise_pkg::REG_STATUS, 32'h0);
        check(32'(q[12:8] >= 5'd15), 32'h1);
        // settling length per slope
        for (int s = 0; s < 4; s++) begin
            f = (s == 2) ? 1 : 0;
            wb(1'b1, noise_pkg::REG_CTRL, 32'((s << 4) | (f << 8)));
            n = 0;
            while (nvalid !== 1'b1) begin
                @(posedge ref_clk_i);
                n++;
            end
            t = n / TICK - waits[s] - (64 << f);
            check(32'(t >= -2 && t <= 1), 32'h1);
        end
        // constant input: mean is the input, no noise
        rd(noise_pkg::REG_X_MEAN, {{8{cx[23]}}, cx});
        rd(noise_pkg::REG_Y_MEAN, {{8{cy[23]}}, cy});
        rd(noise_pkg::REG_X_MAD, 32'h0);
        rd(noise_pkg::REG_Y_NOISE, 32'h0);
        // each display choice routes its quantity
        for (int d = 0; d < 4; d++) begin
            wb(1'b1, noise_pkg::REG_CTRL, 32'h30 | 32'(d << 12));
            dq.push_back(d == 0 ? {{8{cx[23]}}, cx} : d == 1 ? {{8{cy[23]}}, cy} : 32'h0);
            repeat (3 * TICK) @(posedge ref_clk_i);
            check({31'h0, nvalid}, 32'h1);
        end
        // sensitivity change restarts settling
        r = $urandom_range(0, 31);
        wb(1'b1, noise_pkg::REG_SENS, 32'(r));
        rd(noise_pkg::REG_SENS, 32'(r));
        wb(1'b0, noise_pkg::REG_STATUS, 32'h0);
        check(32'(q[1:0]), 32'h2);
        // noisy X, steady Y
        rnd <= 1'b1;
        repeat (100 * TICK) @(posedge ref_clk_i);
        wb(1'b0, noise_pkg::REG_X_MAD, 32'h0);
        check(32'(q != 32'h0), 32'h1);
        rd(noise_pkg::REG_Y_MAD, 32'h0);
        wb(1'b0, noise_pkg::REG_X_NOISE, 32'h0);
        check(32'(q != 32'h0), 32'h1);
        // stop the source, drain the FIFO
        rnd <= 1'b0;
        en  <= 1'b0;
        repeat (20 * TICK) @(posedge ref_clk_i);
        wb(1'b0, noise_pkg::REG_STATUS, 32'h0);
        check(32'(q[12:8]), 32'h0);
        check({31'h0, s_ready}, 32'h1);
        final_report();
    end
endmodule

// *** noise_fifo.sv ***
// noise_fifo: synchronous FIFO for X/Y sample pairs
// assumes one clock; ready on the write side is a registered flag
`timescale 1ns/1ps
module noise_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 16
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       in_valid_i,
    output logic                            in_ready_o,
    input  wire logic [WIDTH-1:0]           in_data_i,
    output logic                            out_valid_o,
    input  wire logic                       out_ready_i,
    output logic [WIDTH-1:0]                out_data_o,
    output logic [$clog2(DEPTH+1)-1:0]      level_o
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic             push;
    logic             pop;

    // handshakes on both sides
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem[rd_ptr_q];
    assign level_o     = count_q;

    // next fill level
    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // storage array
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers, level and ready flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
            end
            count_q    <= count_d;
            in_ready_o <= (count_d != CNT_W'(DEPTH)); // stalls the source when full
        end
    end

endmodule

// *** noise_pkg.sv ***
// noise_pkg: constants, register map and types of the noise estimator
// assumes a 50 MHz system clock and 24-bit signed X/Y samples
package noise_pkg;

    // clock and sample tick
    localparam int SYS_CLK_HZ     = 50_000_000;
    localparam int SAMPLE_RATE_HZ = 512;
    localparam int TICK_CYCLES    = SYS_CLK_HZ / SAMPLE_RATE_HZ;

    // data path widths
    localparam int DATA_W     = 24;
    localparam int ACC_W      = 48;
    localparam int ACC_FRAC   = 22;
    localparam int FIFO_DEPTH = 16;
    localparam int SCALE_FRAC = 16;
    localparam int SETTLE_W   = 24;

    // register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_SENS    = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_X_NOISE = 8'h0C;
    localparam logic [7:0] REG_Y_NOISE = 8'h10;
    localparam logic [7:0] REG_X_MEAN  = 8'h14;
    localparam logic [7:0] REG_Y_MEAN  = 8'h18;
    localparam logic [7:0] REG_X_MAD   = 8'h1C;
    localparam logic [7:0] REG_Y_MAD   = 8'h20;

    // control fields
    localparam int CTRL_TC_LSB    = 0;
    localparam int CTRL_SLOPE_LSB = 4;
    localparam int CTRL_AVG_LSB   = 8;
    localparam int CTRL_SEL_LSB   = 12;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_3337;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0117;
    localparam logic [31:0] SENS_MASK  = 32'h0000_001F;
    localparam logic [31:0] SENS_RST   = 32'h0000_0000;
    localparam logic [3:0]  TC_MAX     = 4'hF;

    // status fields
    localparam int STAT_VALID_BIT  = 0;
    localparam int STAT_SETTLE_BIT = 1;
    localparam int STAT_LEVEL_LSB  = 8;

    // averaging time: 2^(tc + AVG_MIN_EXP + field) ticks, capped to 64T
    localparam logic [4:0] AVG_MIN_EXP = 5'h04;
    localparam logic [4:0] AVG_MAX_EXP = 5'h06;
    localparam logic [3:0] SETTLE_AVG_MULT = 4'h4;

    // filter wait time in multiples of T
    localparam logic [3:0] WAIT_6DB  = 4'h5;
    localparam logic [3:0] WAIT_12DB = 4'h7;
    localparam logic [3:0] WAIT_18DB = 4'h9;
    localparam logic [3:0] WAIT_24DB = 4'hA;

    // Q16 of 1.2533*sqrt(2^(e mod 2)*T/k) for even and odd exponents e
    localparam logic [14:0] SCALE_6DB_EVEN  = 15'h1C5C;
    localparam logic [14:0] SCALE_6DB_ODD   = 15'h281C;
    localparam logic [14:0] SCALE_12DB_EVEN = 15'h281B;
    localparam logic [14:0] SCALE_12DB_ODD  = 15'h38B8;
    localparam logic [14:0] SCALE_18DB_EVEN = 15'h2E4F;
    localparam logic [14:0] SCALE_18DB_ODD  = 15'h417E;
    localparam logic [14:0] SCALE_24DB_EVEN = 15'h32BB;
    localparam logic [14:0] SCALE_24DB_ODD  = 15'h47BF;

    typedef enum logic [1:0] {SLOPE_6DB, SLOPE_12DB, SLOPE_18DB, SLOPE_24DB} slope_t;
    typedef enum logic [1:0] {SEL_X, SEL_Y, SEL_X_NOISE, SEL_Y_NOISE} disp_sel_t;

endpackage

// *** sample_source.sv ***
// sample_source: model of the filter chain that feeds X/Y pairs
// assumes a pair is taken at a rising edge with valid and ready high
`timescale 1ns/1ps
module sample_source (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        en_i,
    input  wire logic [23:0] x_i,
    input  wire logic [23:0] y_i,
    input  wire logic        ready_i,
    output logic             valid_o,
    output logic      [23:0] x_o,
    output logic      [23:0] y_o
);
    // offer a pair, hold it until taken, then scramble the idle lines
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            x_o     <= 24'h0;
            y_o     <= 24'h0;
        end else if (valid_o && ready_i) begin
            valid_o <= 1'b0;
            x_o     <= ~x_o;
            y_o     <= ~y_o;
        end else if (!valid_o && en_i) begin
            valid_o <= 1'b1;
            x_o     <= x_i;
            y_o     <= y_i;
        end
    end
endmodule
